//--- sscc_pkg.sv
// constants, types and encodings for the speed setpoint and current clamp block
// assumes one 100 MHz clock and a synchronous active-high reset
//
// Summary of operation
// - setpoint two = analog times gain, polarity
// - analog two sampled on current-loop tick
// - sum four setpoints, clamp to max/min
// - bypass routes analog two to current demand
// - bypass clear: demand from speed loop
// - full 10 V analog equals 100 percent
// - extra current term added before clamping
// - four independent clamps, any may restrict
// - symmetric clamp at plus/minus positive clamp
// - asymmetric: positive upper, negative lower bound
// - both clamps scaled by limit scale factor
// - master limit symmetric, unscaled, default 200
// - non-regenerative mode zeroes negative demand
// - error = demand minus feedback, PI
// - hold conduction boundary threshold, default 12
// - fault latch, drive-ok, run clears if auto
// - stall alarm gate blocks contactor trip
// - feedback and encoder alarm gates
// - serial receive error alarm gate
// - percent values scaled by one hundred
// - logic parameters one bit, on is 1
package sscc_pkg;

  // ****************************************************************
  // number formats
  // ****************************************************************
  localparam int VAL_W = 18;
  localparam int ACC_W = 48;
  typedef logic signed [VAL_W-1:0] sscc_val_t;
  typedef logic signed [ACC_W-1:0] sscc_acc_t;

  localparam sscc_val_t PCT_100 = 18'sh02710;
  localparam sscc_val_t PCT_105 = 18'sh02904;
  localparam sscc_val_t PCT_200 = 18'sh04e20;
  localparam sscc_val_t PCT_12 = 18'sh004b0;
  localparam sscc_val_t VAL_MAX = 18'sh1ffff;
  localparam sscc_val_t VAL_MIN = -18'sh20000;
  // ratio and gains are scaled by 10000 and 100
  localparam sscc_val_t RATIO_ONE = 18'sh02710;
  localparam sscc_val_t RATIO_LIM = 18'sh07530;
  localparam sscc_val_t GAIN_ONE = 18'sh00064;
  localparam int RATIO_DIV = 10000;
  localparam int GAIN_DIV = 100;
  localparam int GAIN_SHIFT = 0;

  // ****************************************************************
  // apb register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_SP1 = 8'h00;
  localparam logic [7:0] OFS_SP3 = 8'h04;
  localparam logic [7:0] OFS_SP4 = 8'h08;
  localparam logic [7:0] OFS_RATIO = 8'h0c;
  localparam logic [7:0] OFS_MAXD = 8'h10;
  localparam logic [7:0] OFS_MIND = 8'h14;
  localparam logic [7:0] OFS_EXTRA = 8'h18;
  localparam logic [7:0] OFS_POSC = 8'h1c;
  localparam logic [7:0] OFS_NEGC = 8'h20;
  localparam logic [7:0] OFS_SCALE = 8'h24;
  localparam logic [7:0] OFS_MAST = 8'h28;
  localparam logic [7:0] OFS_KP = 8'h2c;
  localparam logic [7:0] OFS_KI = 8'h30;
  localparam logic [7:0] OFS_DISC = 8'h34;
  localparam logic [7:0] OFS_CTRL = 8'h38;
  localparam logic [7:0] OFS_STAT = 8'h3c;
  localparam logic [7:0] OFS_SPD = 8'h40;
  localparam logic [7:0] OFS_IDEM = 8'h44;
  localparam logic [7:0] OFS_SP2 = 8'h48;
  localparam logic [7:0] OFS_PIOUT = 8'h4c;

  // ****************************************************************
  // control bit positions and reset value
  // ****************************************************************
  localparam int CB_POL = 0;
  localparam int CB_BYP = 1;
  localparam int CB_ASYM = 2;
  localparam int CB_REGEN = 3;
  localparam int CB_AUTOCLR = 4;
  localparam int CB_STALL = 5;
  localparam int CB_FBK = 6;
  localparam int CB_ENC = 7;
  localparam int CB_SER = 8;
  localparam int CTRL_W = 9;
  // polarity positive, regen on, auto clear on, stall gate inhibited,
  // the other alarm gates enabled
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h1d9;

  // status bits
  localparam int SB_FAULT = 0;
  localparam int SB_OK = 1;
  localparam int SB_DISC = 2;

  // analog channel: 10 V full scale code
  localparam int ADC_W = 12;
  localparam sscc_val_t ADC_FS = 18'sh007ff;

  typedef enum logic [1:0] {
    SSCC_IDLE = 2'b00,
    SSCC_SETUP = 2'b01,
    SSCC_ACCESS = 2'b10
  } sscc_apb_e;

endpackage

//--- sscc_sat_if.sv
// interface carrying one signed saturating multiply between modules
// assumes both ends on CLK
interface sscc_sat_if;
  import sscc_pkg::*;
  sscc_val_t a;
  sscc_val_t b;
  sscc_val_t q;
  modport user (output a, output b, input q);
  modport unit (input a, input b, output q);
endinterface

//--- sscc_scale.sv
// scaled multiply: q = a * b / 10000, saturated, registered output
// assumes operands from the same clock domain
module sscc_scale
  import sscc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // operands and result
  sscc_sat_if.unit mul
);
  sscc_acc_t prod;
  sscc_acc_t quot;
  sscc_val_t q_next;
  sscc_val_t q_reg;

  assign prod = ACC_W'(mul.a) * ACC_W'(mul.b);
  assign quot = prod / ACC_W'(RATIO_DIV);
  assign q_next = (quot > ACC_W'(VAL_MAX)) ? VAL_MAX :
                  (quot < ACC_W'(VAL_MIN)) ? VAL_MIN : VAL_W'(quot);
  assign mul.q = q_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end
endmodule // sscc_scale

//--- sscc_top.sv
// speed reference summing and armature current demand clamp with PI
// assumes APB master on CLK, analog code already on CLK, scan tick a pulse
//
// The APB slave port and the placing of the registers were left to the implementer.
module sscc_top
  import sscc_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // loop inputs
  input wire logic SCAN_TICK,
  input wire logic signed [ADC_W-1:0] ANALOG_TWO,
  input wire logic signed [VAL_W-1:0] SPEED_LOOP_DEMAND,
  input wire logic signed [VAL_W-1:0] CURRENT_FEEDBACK,
  input wire logic signed [VAL_W-1:0] PROFILE_CLAMP,
  input wire logic signed [VAL_W-1:0] OVERLOAD_CLAMP,
  // alarms and run
  input wire logic RUN_CMD,
  input wire logic STALL_ALARM,
  input wire logic FEEDBACK_ALARM,
  input wire logic ENCODER_ALARM,
  input wire logic SERIAL_RX_ALARM,
  input wire logic OTHER_FAULT,
  // outputs
  output logic signed [VAL_W-1:0] SPEED_REFERENCE,
  output logic signed [VAL_W-1:0] CURRENT_DEMAND,
  output logic signed [VAL_W-1:0] PHASE_ANGLE,
  output logic DISCONTINUOUS,
  output logic DRIVE_OK,
  output logic CONTACTOR_TRIP
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic sscc_val_t sat(input sscc_acc_t v);
    sat = (v > ACC_W'(VAL_MAX)) ? VAL_MAX : (v < ACC_W'(VAL_MIN)) ? VAL_MIN : VAL_W'(v);
  endfunction

  function automatic sscc_val_t clampv(input sscc_val_t v, input sscc_val_t hi,
                                       input sscc_val_t lo);
    clampv = (v > hi) ? hi : (v < lo) ? lo : v;
  endfunction

  function automatic sscc_val_t lim(input sscc_val_t v, input sscc_val_t lo,
                                    input sscc_val_t hi);
    lim = clampv(v, hi, lo);
  endfunction

  // ****************************************************************
  // parameter registers
  // ****************************************************************
  sscc_val_t sp1_reg, sp3_reg, sp4_reg;
  sscc_val_t setpoint_two_gain_reg;
  sscc_val_t max_dem_reg, min_dem_reg;
  sscc_val_t extra_current_term_reg;
  sscc_val_t upper_clamp_reg, lower_current_limit_reg;
  sscc_val_t limit_scale_factor_reg, master_current_limit_reg;
  sscc_val_t kp_reg, ki_reg, disc_thr_reg;
  logic [CTRL_W-1:0] ctrl_reg;

  logic setpoint_two_polarity, current_demand_bypass, asym_select, regenerative_select;
  logic auto_clear, stall_gate, feedback_alarm_gate, encoder_gate, serial_rx_error_gate;
  // one bit per logic parameter, on = 1
  assign setpoint_two_polarity = ctrl_reg[CB_POL];
  assign current_demand_bypass = ctrl_reg[CB_BYP];
  assign asym_select = ctrl_reg[CB_ASYM];
  assign regenerative_select = ctrl_reg[CB_REGEN];
  assign auto_clear = ctrl_reg[CB_AUTOCLR];
  assign stall_gate = ctrl_reg[CB_STALL];
  assign feedback_alarm_gate = ctrl_reg[CB_FBK];
  assign encoder_gate = ctrl_reg[CB_ENC];
  assign serial_rx_error_gate = ctrl_reg[CB_SER];

  // ****************************************************************
  // apb decode
  // ****************************************************************
  logic wr_en, rd_en, hit;
  sscc_val_t wval;
  assign PREADY = 1'b1;
  assign wr_en = PSEL & PENABLE & PWRITE;
  assign rd_en = PSEL & PENABLE & ~PWRITE;
  assign wval = PWDATA[VAL_W-1:0];
  assign hit = (PADDR <= OFS_PIOUT) && (PADDR[1:0] == 2'b00);
  assign PSLVERR = PSEL & PENABLE & ~hit;

  // ****************************************************************
  // analog channel sampling and setpoint two scaling
  // ****************************************************************
  sscc_val_t a2_reg;
  sscc_val_t a2_pct;
  sscc_val_t scaled_setpoint_two;
  sscc_sat_if mul_if ();

  always_ff @(posedge CLK) begin
    if (RST) begin
      a2_reg <= '0;
    end else if (SCAN_TICK) begin
      a2_reg <= VAL_W'(ANALOG_TWO);
    end
  end

  // full-scale code maps to 100 percent
  assign a2_pct = sat(ACC_W'(a2_reg) * ACC_W'(PCT_100) / ACC_W'(ADC_FS));
  assign mul_if.a = a2_pct;
  assign mul_if.b = setpoint_two_polarity ? setpoint_two_gain_reg :
                    sat(-ACC_W'(setpoint_two_gain_reg));
  sscc_scale u_scale (
    .clk(CLK),
    .rst(RST),
    .mul(mul_if.unit)
  );
  assign scaled_setpoint_two = lim(mul_if.q, -PCT_105, PCT_105);

  // ****************************************************************
  // speed reference
  // ****************************************************************
  sscc_acc_t sp_sum;
  sscc_val_t spd_next;
  // bypass removes channel two from the sum
  assign sp_sum = ACC_W'(sp1_reg) + ACC_W'(sp3_reg) + ACC_W'(sp4_reg) +
                  (current_demand_bypass ? '0 : ACC_W'(scaled_setpoint_two));
  assign spd_next = clampv(sat(sp_sum), max_dem_reg, min_dem_reg);

  // ****************************************************************
  // current demand and clamps
  // ****************************************************************
  sscc_val_t dem_sel, dem_add, dem_regen, scaled_hi, scaled_lo;
  sscc_val_t c1_hi, c1_lo, c2, dem_next;
  assign dem_sel = current_demand_bypass ? a2_pct : SPEED_LOOP_DEMAND;
  assign dem_add = sat(ACC_W'(dem_sel) + ACC_W'(extra_current_term_reg));
  assign dem_regen = (!regenerative_select && dem_add < 0) ? '0 : dem_add;
  assign scaled_hi = sat(ACC_W'(upper_clamp_reg) * ACC_W'(limit_scale_factor_reg)
                         / ACC_W'(RATIO_DIV));
  assign scaled_lo = asym_select ?
                     sat(ACC_W'(lower_current_limit_reg) * ACC_W'(limit_scale_factor_reg)
                         / ACC_W'(RATIO_DIV)) :
                     sat(-ACC_W'(scaled_hi));
  // profile and overload clamps are symmetric magnitudes
  assign c1_hi = (PROFILE_CLAMP < OVERLOAD_CLAMP) ? PROFILE_CLAMP : OVERLOAD_CLAMP;
  assign c1_lo = sat(-ACC_W'(c1_hi));
  assign c2 = clampv(clampv(dem_regen, scaled_hi, scaled_lo), c1_hi, c1_lo);
  assign dem_next = clampv(c2, master_current_limit_reg,
                           sat(-ACC_W'(master_current_limit_reg)));

  // ****************************************************************
  // current PI
  // ****************************************************************
  sscc_val_t err, integ_reg, integ_next, pi_next;
  sscc_acc_t p_term, i_inc;
  assign err = sat(ACC_W'(CURRENT_DEMAND) - ACC_W'(CURRENT_FEEDBACK));
  assign p_term = ACC_W'(err) * ACC_W'(kp_reg) / ACC_W'(GAIN_DIV);
  assign i_inc = ACC_W'(err) * ACC_W'(ki_reg) / ACC_W'(GAIN_DIV * GAIN_DIV);
  assign integ_next = sat(ACC_W'(integ_reg) + i_inc);
  assign pi_next = sat(p_term + ACC_W'(integ_reg));

  // ****************************************************************
  // loop state, updated on the scan tick
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (RST) begin
      SPEED_REFERENCE <= '0;
      CURRENT_DEMAND <= '0;
      integ_reg <= '0;
      PHASE_ANGLE <= '0;
      DISCONTINUOUS <= 1'b0;
    end else if (SCAN_TICK) begin
      SPEED_REFERENCE <= spd_next;
      CURRENT_DEMAND <= dem_next;
      integ_reg <= integ_next;
      PHASE_ANGLE <= pi_next;
      DISCONTINUOUS <= (CURRENT_FEEDBACK < disc_thr_reg);
    end
  end

  // ****************************************************************
  // alarms and fault latch
  // ****************************************************************
  logic fault_reg, fault_in, run_s1, run_s2, run_prev, run_rise, clear_ok;
  assign fault_in = (STALL_ALARM & stall_gate) | (FEEDBACK_ALARM & feedback_alarm_gate) |
                    (ENCODER_ALARM & encoder_gate) | (SERIAL_RX_ALARM & serial_rx_error_gate) |
                    OTHER_FAULT;
  assign run_rise = run_s2 & ~run_prev;
  assign clear_ok = auto_clear & run_rise;

  always_ff @(posedge CLK) begin
    if (RST) begin
      run_s1 <= 1'b0;
      run_s2 <= 1'b0;
      run_prev <= 1'b0;
      fault_reg <= 1'b0;
      DRIVE_OK <= 1'b0;
      CONTACTOR_TRIP <= 1'b0;
    end else begin
      run_s1 <= RUN_CMD;
      run_s2 <= run_s1;
      run_prev <= run_s2;
      // a new fault wins over a clear
      fault_reg <= fault_in | (fault_reg & ~clear_ok);
      DRIVE_OK <= ~fault_reg & ~fault_in;
      CONTACTOR_TRIP <= fault_in;
    end
  end

  // ****************************************************************
  // register writes
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (RST) begin
      sp1_reg <= '0;
      sp3_reg <= '0;
      sp4_reg <= '0;
      setpoint_two_gain_reg <= RATIO_ONE;
      max_dem_reg <= PCT_105;
      min_dem_reg <= -PCT_105;
      extra_current_term_reg <= '0;
      upper_clamp_reg <= PCT_100;
      lower_current_limit_reg <= -PCT_100;
      limit_scale_factor_reg <= PCT_100;
      master_current_limit_reg <= PCT_200;
      kp_reg <= sscc_val_t'(45 * GAIN_ONE);
      ki_reg <= 18'sh0015e;
      disc_thr_reg <= PCT_12;
      ctrl_reg <= CTRL_RST;
    end else if (wr_en) begin
      if (PADDR == OFS_SP1) begin
        sp1_reg <= lim(wval, -PCT_105, PCT_105);
      end else if (PADDR == OFS_SP3) begin
        sp3_reg <= lim(wval, -PCT_105, PCT_105);
      end else if (PADDR == OFS_SP4) begin
        sp4_reg <= lim(wval, -PCT_105, PCT_105);
      end else if (PADDR == OFS_RATIO) begin
        setpoint_two_gain_reg <= lim(wval, -RATIO_LIM, RATIO_LIM);
      end else if (PADDR == OFS_MAXD) begin
        max_dem_reg <= lim(wval, '0, PCT_105);
      end else if (PADDR == OFS_MIND) begin
        min_dem_reg <= lim(wval, -PCT_105, '0);
      end else if (PADDR == OFS_EXTRA) begin
        extra_current_term_reg <= lim(wval, -PCT_200, PCT_200);
      end else if (PADDR == OFS_POSC) begin
        upper_clamp_reg <= lim(wval, -PCT_100, PCT_100);
      end else if (PADDR == OFS_NEGC) begin
        lower_current_limit_reg <= lim(wval, -PCT_100, PCT_100);
      end else if (PADDR == OFS_SCALE) begin
        limit_scale_factor_reg <= lim(wval, '0, PCT_200);
      end else if (PADDR == OFS_MAST) begin
        master_current_limit_reg <= lim(wval, '0, PCT_200);
      end else if (PADDR == OFS_KP) begin
        kp_reg <= lim(wval, '0, PCT_200);
      end else if (PADDR == OFS_KI) begin
        ki_reg <= lim(wval, '0, PCT_200);
      end else if (PADDR == OFS_DISC) begin
        disc_thr_reg <= lim(wval, '0, PCT_200);
      end else if (PADDR == OFS_CTRL) begin
        ctrl_reg <= PWDATA[CTRL_W-1:0];
      end
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  sscc_val_t rsel;
  logic [31:0] rword;
  assign rsel = (PADDR == OFS_SP1) ? sp1_reg :
                (PADDR == OFS_SP3) ? sp3_reg :
                (PADDR == OFS_SP4) ? sp4_reg :
                (PADDR == OFS_RATIO) ? setpoint_two_gain_reg :
                (PADDR == OFS_MAXD) ? max_dem_reg :
                (PADDR == OFS_MIND) ? min_dem_reg :
                (PADDR == OFS_EXTRA) ? extra_current_term_reg :
                (PADDR == OFS_POSC) ? upper_clamp_reg :
                (PADDR == OFS_NEGC) ? lower_current_limit_reg :
                (PADDR == OFS_SCALE) ? limit_scale_factor_reg :
                (PADDR == OFS_MAST) ? master_current_limit_reg :
                (PADDR == OFS_KP) ? kp_reg :
                (PADDR == OFS_KI) ? ki_reg :
                (PADDR == OFS_DISC) ? disc_thr_reg :
                (PADDR == OFS_SPD) ? SPEED_REFERENCE :
                (PADDR == OFS_IDEM) ? CURRENT_DEMAND :
                (PADDR == OFS_SP2) ? scaled_setpoint_two :
                (PADDR == OFS_PIOUT) ? PHASE_ANGLE : '0;
  // signed values are sign-extended to the full word
  assign rword = (PADDR == OFS_CTRL) ? {23'h0, ctrl_reg} :
                 (PADDR == OFS_STAT) ? {29'h0, DISCONTINUOUS, DRIVE_OK, fault_reg} :
                 {{(32-VAL_W){rsel[VAL_W-1]}}, rsel};

  always_ff @(posedge CLK) begin
    if (RST) begin
      PRDATA <= '0;
    end else if (PSEL & ~PENABLE & ~PWRITE) begin
      PRDATA <= hit ? rword : 32'h0;
    end else if (rd_en) begin
      PRDATA <= PRDATA;
    end
  end

endmodule // sscc_top

//--- sscc_props.sv
// checker on the ports of sscc_top
// assumes bound to every sscc_top instance, one clock domain
module sscc_props
  import sscc_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // loop inputs
  input wire logic SCAN_TICK,
  input wire logic signed [VAL_W-1:0] PROFILE_CLAMP,
  input wire logic signed [VAL_W-1:0] OVERLOAD_CLAMP,
  input wire logic OTHER_FAULT,
  // outputs
  input wire logic signed [VAL_W-1:0] SPEED_REFERENCE,
  input wire logic signed [VAL_W-1:0] CURRENT_DEMAND,
  input wire logic signed [VAL_W-1:0] PHASE_ANGLE,
  input wire logic DISCONTINUOUS,
  input wire logic DRIVE_OK,
  input wire logic CONTACTOR_TRIP
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  ref_bounds_a: assert property (SPEED_REFERENCE <= PCT_105 && SPEED_REFERENCE >= -PCT_105)
    else $error("speed reference outside 105 percent");
  loop_hold_a: assert property (!SCAN_TICK |=> $stable(SPEED_REFERENCE) && $stable(CURRENT_DEMAND))
    else $error("loop output moved without a scan tick");
  master_lim_a: assert property (CURRENT_DEMAND <= PCT_200 && CURRENT_DEMAND >= -PCT_200)
    else $error("current demand beyond master limit range");
  profile_lim_a: assert property (SCAN_TICK && PROFILE_CLAMP >= 0 |=>
    CURRENT_DEMAND <= $past(PROFILE_CLAMP) && CURRENT_DEMAND >= -$past(PROFILE_CLAMP))
    else $error("current demand beyond profile clamp");
  overload_lim_a: assert property (SCAN_TICK && OVERLOAD_CLAMP >= 0 |=>
    CURRENT_DEMAND <= $past(OVERLOAD_CLAMP) && CURRENT_DEMAND >= -$past(OVERLOAD_CLAMP))
    else $error("current demand beyond overload clamp");
  fault_trip_a: assert property (OTHER_FAULT |=> CONTACTOR_TRIP)
    else $error("fault did not trip contactor");
  fault_ok_a: assert property (OTHER_FAULT |-> ##2 !DRIVE_OK)
    else $error("drive ok stayed high on fault");
  phase_hold_a: assert property (!SCAN_TICK |=> $stable(PHASE_ANGLE))
    else $error("phase angle moved without a scan tick");
  disc_hold_a: assert property (!SCAN_TICK |=> $stable(DISCONTINUOUS))
    else $error("discontinuous flag moved without a scan tick");
endmodule // sscc_props

bind sscc_top sscc_props chk (.CLK(CLK), .RST(RST), .SCAN_TICK(SCAN_TICK),
  .PROFILE_CLAMP(PROFILE_CLAMP), .OVERLOAD_CLAMP(OVERLOAD_CLAMP), .OTHER_FAULT(OTHER_FAULT),
  .SPEED_REFERENCE(SPEED_REFERENCE), .CURRENT_DEMAND(CURRENT_DEMAND),
  .PHASE_ANGLE(PHASE_ANGLE), .DISCONTINUOUS(DISCONTINUOUS), .DRIVE_OK(DRIVE_OK),
  .CONTACTOR_TRIP(CONTACTOR_TRIP));

//--- sscc_loop_model.sv
// far side model: speed loop output, current feedback and scan tick
// assumes the bench sets the demand and feedback to be presented
module sscc_loop_model
  import sscc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // commanded values
  input wire logic signed [VAL_W-1:0] demand_set,
  input wire logic signed [VAL_W-1:0] feedback_set,
  // toward the block
  output logic scan_tick,
  output logic signed [VAL_W-1:0] speed_demand,
  output logic signed [VAL_W-1:0] current_fbk
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] phase_reg;

  // tick every fourth cycle; values move only on ticks
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_reg <= '0;
      scan_tick <= 1'b0;
      speed_demand <= '0;
      current_fbk <= '0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
      scan_tick <= (phase_reg == 2'h3);
      if (scan_tick) begin
        speed_demand <= demand_set;
        current_fbk <= feedback_set;
      end
    end
  end
endmodule // sscc_loop_model

//--- testbench.sv
// self-checking bench for sscc_top with the loop model on its far side
// assumes a zero-wait apb slave and a scan tick every fourth cycle
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import sscc_pkg::*;

  logic CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, RUN_CMD = 0;
  logic [7:0] PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA;
  logic PREADY, PSLVERR, tick, disc, ok, trip;
  logic signed [ADC_W-1:0] a2 = '0;
  logic signed [VAL_W-1:0] dem_set = '0, fb_set = 18'sh01388, prof = PCT_200, ovl = PCT_200;
  logic signed [VAL_W-1:0] spd, fbk, sref, idem, phase;
  logic [4:0] alm = '0;
  logic [32:0] notes[$];
  logic [7:0] ofs[12] = '{OFS_RATIO, OFS_MAXD, OFS_MIND, OFS_EXTRA, OFS_POSC, OFS_NEGC,
    OFS_SCALE, OFS_MAST, OFS_KP, OFS_KI, OFS_DISC, OFS_CTRL};
  int dflt[12] = '{10000, 10500, -10500, 0, 10000, -10000, 10000, 20000, 4500, 350, 1200, 'h1d9};
  int fail_count = 0, n_compared = 0;
  int s1, s3, s4, a, ratio, pol, byp, asym, regen, ext, posc, negc, scale, mast, mx, mn, d, up, lo;

  always #5 CLK = ~CLK;

  sscc_top dut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SCAN_TICK(tick), .ANALOG_TWO(a2), .SPEED_LOOP_DEMAND(spd), .CURRENT_FEEDBACK(fbk),
    .PROFILE_CLAMP(prof), .OVERLOAD_CLAMP(ovl), .RUN_CMD(RUN_CMD), .STALL_ALARM(alm[0]),
    .FEEDBACK_ALARM(alm[1]), .ENCODER_ALARM(alm[2]), .SERIAL_RX_ALARM(alm[3]),
    .OTHER_FAULT(alm[4]), .SPEED_REFERENCE(sref), .CURRENT_DEMAND(idem), .PHASE_ANGLE(phase),
    .DISCONTINUOUS(disc), .DRIVE_OK(ok), .CONTACTOR_TRIP(trip));
  sscc_loop_model model (.clk(CLK), .rst(RST), .demand_set(dem_set), .feedback_set(fb_set),
    .scan_tick(tick), .speed_demand(spd), .current_fbk(fbk));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results;
    if (fail_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // read result compared against the oldest note
  always @(posedge CLK) begin
    if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE) begin
      check({PSLVERR, PRDATA}, notes.size() > 0 ? notes.pop_front() : 'x);
    end
  end

  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                     input logic [32:0] e);
    int n;
    if (!w) notes.push_back(e);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= ad;
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    n = 0;
    @(posedge CLK);
    while (PREADY !== 1'b1) begin
      n++;
      if (n > 50) begin
        fail_count++;
        results();
      end
      @(posedge CLK);
    end
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic wr(input logic [7:0] ad, input int v);
    apb(1'b1, ad, 32'(v), '0);
  endtask

  task automatic rd(input logic [7:0] ad, input int v);
    apb(1'b0, ad, '0, {1'b0, 32'(v)});
  endtask

  task automatic run_pulse;
    RUN_CMD <= 1'b1;
    repeat (6) @(posedge CLK);
    RUN_CMD <= 1'b0;
    repeat (6) @(posedge CLK);
  endtask

  task automatic alarm_pulse(input int i);
    alm[i] <= 1'b1;
    repeat (3) @(posedge CLK);
    alm <= '0;
    repeat (4) @(posedge CLK);
  endtask

  function automatic int lim(input int v, input int l, input int h);
    return v < l ? l : (v > h ? h : v);
  endfunction

  function automatic int rnd(input int m);
    return $urandom_range(2 * m) - m;
  endfunction

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    void'($urandom(32'he9671148));
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    for (int i = 0; i < 12; i++) rd(ofs[i], dflt[i]);
    apb(1'b0, 8'h50, '0, {1'b1, 32'h0});
    wr(OFS_POSC, 15000);
    rd(OFS_POSC, 10000);
    for (int k = 0; k < 24; k++) begin
      s1 = rnd(10500); s3 = rnd(10500); s4 = rnd(10500);
      a = 2047 * ($urandom_range(2) - 1);
      ratio = ($urandom_range(2) == 0) ? 5000 : 10000 * (2 * $urandom_range(1) - 1);
      pol = $urandom_range(1); byp = $urandom_range(1); asym = $urandom_range(1);
      regen = $urandom_range(1);
      if (byp == 1) begin
        ratio = 10000;
        pol = 1;
      end
      ext = rnd(5000); posc = 2 * $urandom_range(5000);
      negc = lim(posc - 2 - 2 * $urandom_range(10000), -10000, posc - 2);
      scale = 5000 * (1 << $urandom_range(2)); mast = $urandom_range(20000);
      mx = $urandom_range(10500); mn = -$urandom_range(10500);
      a2 <= 12'(a); dem_set <= 18'(rnd(25000));
      prof <= 18'($urandom_range(20000)); ovl <= 18'($urandom_range(20000));
      wr(OFS_SP1, s1); wr(OFS_SP3, s3); wr(OFS_SP4, s4); wr(OFS_RATIO, ratio);
      wr(OFS_EXTRA, ext); wr(OFS_POSC, posc); wr(OFS_NEGC, negc); wr(OFS_SCALE, scale);
      wr(OFS_MAST, mast); wr(OFS_MAXD, mx); wr(OFS_MIND, mn);
      wr(OFS_CTRL, 'h1d0 | regen << 3 | asym << 2 | byp << 1 | pol);
      repeat (16) @(posedge CLK);
      d = s1 + s3 + s4 + (byp == 1 ? 0 : a / 2047 * ratio * (2 * pol - 1));
      rd(OFS_SPD, lim(d, mn, mx));
      rd(OFS_SP2, a / 2047 * ratio * (2 * pol - 1));
      d = (byp == 1 ? a / 2047 * 10000 : int'(dem_set)) + ext;
      if (regen == 0 && d < 0) d = 0;
      up = posc * scale / 10000;
      lo = (asym == 1) ? negc * scale / 10000 : -up;
      d = lim(d, lo, up);
      mast = lim(mast, 0, lim(int'(prof), 0, int'(ovl)));
      rd(OFS_IDEM, lim(d, -mast, mast));
    end
    for (int i = 0; i < 5; i++) begin
      for (int g = 0; g < 2; g++) begin
        wr(OFS_CTRL, g == 1 ? 'h019 | ('h020 << i) : 'h019);
        alarm_pulse(i);
        rd(OFS_STAT, (g == 1 || i == 4) ? 1 : 2);
        run_pulse();
        rd(OFS_STAT, 2);
      end
    end
    wr(OFS_CTRL, 'h049);
    alarm_pulse(1);
    run_pulse();
    rd(OFS_STAT, 1);
    wr(OFS_CTRL, 'h059);
    run_pulse();
    rd(OFS_STAT, 2);
    fb_set <= 18'sh004af;
    repeat (16) @(posedge CLK);
    rd(OFS_STAT, 6);
    fb_set <= PCT_12;
    repeat (16) @(posedge CLK);
    rd(OFS_STAT, 2);
    wr(OFS_DISC, 1201);
    repeat (16) @(posedge CLK);
    rd(OFS_STAT, 6);
    results();
  end
endmodule // testbench
